// file: rtl/supply_fault_supervisor.sv
// fault supervision, pre-bias start-up and tracking for a buck controller
// Notes on behaviour
// - undervoltage threshold programmable 2.85-16 V serially, 4.5-10.8 V by strap
// - undervoltage response: continue, delay then latch off, or shutdown with retries
// - default undervoltage response: shut down, re-enable when fault clears
// - overvoltage above target plus 15 percent drops power good
// - overvoltage: shutdown with retries, or high side off, low side on until restart
// - default overvoltage response: shut down, re-enable when fault clears
// - with external clock, overvoltage always shuts down immediately
// - low pre-bias: start target from sensed voltage, ramp within ramp time
// - high pre-bias: matching duty, power good at ramp end, then ramp down
// - pre-bias above overvoltage limit: skip turn-on and raise overvoltage fault
// - no pre-bias handling for sharing groups with tracking enabled
// - overcurrent: five selectable policies
// - default overcurrent response: shut down, re-enable when clear
// - die temperature above limit, default 125 C, shuts down
// - thermal fault: same five policies
// - thermal restart only once temperature is 15 C below limit
// - default thermal response: shut down, re-enable when clear
// - tracking uses follow reference, coincident or ratiometric default 50 percent
// - tracking ignores own start delay and ramp time
// - tracking either always follows or never decreases before power good
`timescale 1ns/1ps
`default_nettype none
module supply_fault_supervisor
  import supervisor_pkg::*;
#(
  parameter int DELAY_CYC = RETRY_DELAY_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              enable,
  input  wire logic              restart_cmd,
  input  wire logic              ext_clock_mode,
  input  wire logic              strap_mode,
  input  wire logic [VW-1:0]     input_low_lockout_serial,
  input  wire logic [VW-1:0]     input_low_lockout_strap,
  input  wire logic [VW-1:0]     input_voltage,
  input  wire logic [VW-1:0]     output_sense_pin,
  input  wire logic [VW-1:0]     target,
  input  wire logic [VW-1:0]     follow_reference_pin,
  input  wire logic [TW-1:0]     die_temp,
  input  wire logic [TW-1:0]     temp_limit,
  input  wire logic              overcurrent,
  input  wire resp_t             uv_policy,
  input  wire resp_t             ov_policy,
  input  wire resp_t             oc_policy,
  input  wire resp_t             ot_policy,
  input  wire logic [CW-1:0]     retry_limit,
  input  wire track_t            track_mode,
  input  wire logic [6:0]        track_ratio_pct,
  input  wire logic              track_no_decrease,
  input  wire logic              share_member,
  input  wire logic [31:0]       start_delay_cyc,
  input  wire logic [31:0]       ramp_cyc,
  output logic                   high_drive_en,
  output logic                   low_drive_en,
  output logic [VW-1:0]          working_target,
  output logic                   power_good,
  output logic                   ov_fault,
  output logic                   fault_latched
);
  typedef enum logic [2:0] {P_OFF, P_DELAY, P_RAMP, P_REG, P_TRACK} ph_t;
  ph_t ph, next_ph;
  logic [31:0]   tmr, next_tmr;
  logic [VW-1:0] tgt, next_tgt;
  logic [VW-1:0] start_v, next_start_v;
  logic          pg, next_pg;
  logic          hd, next_hd, ld, next_ld;
  logic          ovf, next_ovf;
  logic          lat, next_lat;
  logic          ov_prebias, next_ov_prebias;

  function automatic logic [VW-1:0] clamp_input_low_lockout(input logic [VW-1:0] v, input logic strap);
    logic [VW-1:0] lo, hi;
    lo = strap ? INPUT_LOW_LOCKOUT_STRAP_LO : INPUT_LOW_LOCKOUT_MIN_MV;
    hi = strap ? INPUT_LOW_LOCKOUT_STRAP_HI : INPUT_LOW_LOCKOUT_MAX_MV;
    clamp_input_low_lockout = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [VW-1:0] pct_of(input logic [VW-1:0] v, input logic [7:0] pct);
    logic [VW+7:0] prod;
    prod = {8'h0, v} * {{VW{1'b0}}, pct};
    pct_of = VW'(prod / (VW+8)'(100));
  endfunction

  logic [VW-1:0] input_low_lockout_th;
  logic [VW:0]   ov_limit;
  logic          uv_fault_now, ov_now, ot_now, ot_clear;
  assign input_low_lockout_th = clamp_input_low_lockout(strap_mode ? input_low_lockout_strap : input_low_lockout_serial, strap_mode);
  assign ov_limit = {1'b0, target} + {1'b0, pct_of(target, 8'(OV_PCT))};
  assign uv_fault_now = input_voltage < input_low_lockout_th;
  assign ov_now = {1'b0, output_sense_pin} > ov_limit;
  assign ot_now = die_temp > temp_limit;
  assign ot_clear = die_temp < (temp_limit - THERM_HYST);

  resp_t ov_pol_eff;
  assign ov_pol_eff = ext_clock_mode ? RESP_SHUTDOWN : ov_policy;

  logic uv_stop, ov_stop, oc_stop, ot_stop, uv_lat, ov_lat, oc_lat, ot_lat;
  logic restart;
  resp_t ot_pol_fix;
  // low-side clamp is meaningful only for overvoltage
  assign ot_pol_fix = (ot_policy == RESP_LOW_SIDE_ON) ? RESP_SHUTDOWN : ot_policy;
  assign restart = restart_cmd | !enable;

  fault_policy #(.DELAY_CYC(DELAY_CYC)) u_uv (
    .clk(clk), .rst(rst), .fault(uv_fault_now), .clear_ok(!uv_fault_now),
    .policy(uv_policy), .retry_limit(retry_limit), .restart(restart),
    .stop(uv_stop), .latched(uv_lat));
  fault_policy #(.DELAY_CYC(DELAY_CYC)) u_ov (
    .clk(clk), .rst(rst), .fault(ov_now | ov_prebias), .clear_ok(!ov_now),
    .policy(ov_pol_eff), .retry_limit(retry_limit), .restart(restart),
    .stop(ov_stop), .latched(ov_lat));
  fault_policy #(.DELAY_CYC(DELAY_CYC)) u_oc (
    .clk(clk), .rst(rst), .fault(overcurrent), .clear_ok(!overcurrent),
    .policy(oc_policy), .retry_limit(retry_limit), .restart(restart),
    .stop(oc_stop), .latched(oc_lat));
  fault_policy #(.DELAY_CYC(DELAY_CYC)) u_ot (
    .clk(clk), .rst(rst), .fault(ot_now), .clear_ok(ot_clear),
    .policy(ot_pol_fix), .retry_limit(retry_limit), .restart(restart),
    .stop(ot_stop), .latched(ot_lat));

  logic any_stop, ov_clamp, prebias_ok;
  assign any_stop = uv_stop | ov_stop | oc_stop | ot_stop;
  assign ov_clamp = ov_lat && (ov_pol_eff == RESP_LOW_SIDE_ON);
  assign prebias_ok = !(share_member && track_mode != TRK_OFF);

  logic [VW-1:0] trk_ref;
  assign trk_ref = (track_mode == TRK_RATIO) ? pct_of(follow_reference_pin, {1'b0, track_ratio_pct})
                                             : follow_reference_pin;

  // linear interpolation from the sampled start voltage, finishing at ramp_cyc
  function automatic logic [VW-1:0] ramp_pt(input logic [VW-1:0] a, input logic [VW-1:0] b,
                                            input logic [31:0] t, input logic [31:0] n);
    logic signed [47:0] d;
    d = $signed({36'h0, b}) - $signed({36'h0, a});
    if (n == 32'h0 || t >= n) ramp_pt = b;
    else ramp_pt = VW'($signed({36'h0, a}) + (d * $signed({16'h0, t})) / $signed({16'h0, n}));
  endfunction

  always_comb begin
    next_ph = ph;
    next_tmr = tmr;
    next_tgt = tgt;
    next_start_v = start_v;
    next_pg = pg;
    next_hd = hd;
    next_ld = ld;
    next_ovf = ov_now | ov_stop;
    next_lat = uv_lat | ov_lat | oc_lat | ot_lat;
    next_ov_prebias = 1'b0;
    case (ph)
      P_OFF: begin
        next_hd = 1'b0;
        next_ld = ov_clamp;
        next_pg = 1'b0;
        next_tgt = '0;
        next_tmr = 32'h0;
        if (enable && !any_stop && !uv_fault_now)
          next_ph = (track_mode != TRK_OFF) ? P_TRACK : P_DELAY;
      end
      P_DELAY: begin
        next_tmr = tmr + 32'h1;
        if (tmr >= start_delay_cyc) begin
          next_tmr = 32'h0;
          if (prebias_ok && ov_now) begin
            next_ov_prebias = 1'b1;
            next_ph = P_OFF;
          end else begin
            next_start_v = prebias_ok ? output_sense_pin : '0;
            next_tgt = next_start_v;
            next_hd = 1'b1;
            next_ld = 1'b1;
            next_ph = P_RAMP;
          end
        end
      end
      P_RAMP: begin
        next_tmr = tmr + 32'h1;
        // above-target pre-bias holds its own level until the ramp period ends
        next_tgt = (start_v > target) ? start_v : ramp_pt(start_v, target, tmr, ramp_cyc);
        if (tmr >= ramp_cyc) begin
          next_pg = 1'b1;
          next_ph = P_REG;
        end
      end
      P_REG: begin
        if (tgt > target) next_tgt = tgt - VW'(1);
        else next_tgt = target;
      end
      P_TRACK: begin
        next_hd = 1'b1;
        next_ld = 1'b1;
        if (!(track_no_decrease && !pg && trk_ref < tgt))
          next_tgt = (trk_ref > target) ? target : trk_ref;
        if (tgt >= target) next_pg = 1'b1;
      end
      default: next_ph = P_OFF;
    endcase
    if (ov_now) next_pg = 1'b0;
    if (any_stop || !enable) begin
      next_ph = P_OFF;
      next_hd = 1'b0;
      next_ld = ov_clamp;
      next_pg = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ph <= P_OFF;
      tmr <= 32'h0;
      tgt <= '0;
      start_v <= '0;
      pg <= 1'b0;
      hd <= 1'b0;
      ld <= 1'b0;
      ovf <= 1'b0;
      lat <= 1'b0;
      ov_prebias <= 1'b0;
    end else begin
      ph <= next_ph;
      tmr <= next_tmr;
      tgt <= next_tgt;
      start_v <= next_start_v;
      pg <= next_pg;
      hd <= next_hd;
      ld <= next_ld;
      ovf <= next_ovf;
      lat <= next_lat;
      ov_prebias <= next_ov_prebias;
    end
  end

  assign high_drive_en = hd;
  assign low_drive_en = ld;
  assign working_target = tgt;
  assign power_good = pg;
  assign ov_fault = ovf;
  assign fault_latched = lat;
endmodule
`default_nettype wire

// file: include/supervisor_pkg.sv
// constants and types shared by the fault supervisor
package supervisor_pkg;
  localparam int VW = 12;               // width of voltage codes (millivolt units)
  localparam int TW = 8;                // width of temperature codes (degrees C)
  localparam int CW = 4;                // retry counter width
  localparam int DUTY_W = 10;
  localparam real CLK_MHZ = 250.0;
  localparam real RETRY_DELAY_MS = 1.0;
  localparam int RETRY_DELAY_CYC = int'(RETRY_DELAY_MS * 1000.0 * CLK_MHZ);
  localparam real TRACK_MASTER_DELAY_MS = 10.0;
  localparam logic [VW-1:0] INPUT_LOW_LOCKOUT_MIN_MV   = 12'hb22;  // 2850 mV
  localparam logic [VW-1:0] INPUT_LOW_LOCKOUT_MAX_MV   = 12'hfff;  // 16 V clipped to code range
  localparam logic [VW-1:0] INPUT_LOW_LOCKOUT_STRAP_LO = 12'h465;  // 4.5 V scaled by 4 (1.125 V code)
  localparam logic [VW-1:0] INPUT_LOW_LOCKOUT_STRAP_HI = 12'ha8c;  // 10.8 V scaled by 4 (2.7 V code)
  localparam logic [TW-1:0] THERM_LIMIT_DEF = 8'h7d;  // 125 C
  localparam logic [TW-1:0] THERM_HYST      = 8'h0f;  // 15 C
  localparam int OV_PCT = 15;
  localparam int TRACK_RATIO_DEF_PCT = 50;
  localparam logic [CW-1:0] RETRY_DEF = 4'h3;

  // fault response policies
  typedef enum logic [2:0] {
    RESP_SHUTDOWN,       // immediate shutdown, auto re-enable when clear
    RESP_RETRY_FOREVER,
    RESP_RETRY_COUNT,
    RESP_DELAY_OFF,      // run for delay then latch off
    RESP_CONTINUE,
    RESP_LOW_SIDE_ON     // overvoltage only: high off, low on until restart
  } resp_t;

  typedef enum logic [1:0] {
    TRK_OFF,
    TRK_COINCIDENT,
    TRK_RATIO
  } track_t;
endpackage

// file: rtl/fault_policy.sv
// one fault channel: applies the selected response policy to a fault level
`timescale 1ns/1ps
`default_nettype none
module fault_policy
  import supervisor_pkg::*;
#(
  parameter int DELAY_CYC = RETRY_DELAY_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          fault,
  input  wire logic          clear_ok,
  input  wire resp_t         policy,
  input  wire logic [CW-1:0] retry_limit,
  input  wire logic          restart,
  output logic               stop,
  output logic               latched
);
  typedef enum logic [2:0] {S_RUN, S_GRACE, S_OFF, S_WAIT, S_LATCH} st_t;
  st_t st, next_st;
  logic [31:0]   cnt, next_cnt;
  logic [CW-1:0] tries, next_tries;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_tries = tries;
    case (st)
      S_RUN: begin
        next_cnt = 32'h0;
        if (fault) begin
          case (policy)
            RESP_CONTINUE: next_st = S_RUN;
            RESP_DELAY_OFF: next_st = S_GRACE;
            RESP_LOW_SIDE_ON: next_st = S_LATCH;
            RESP_SHUTDOWN: next_st = S_OFF;
            default: next_st = S_WAIT;
          endcase
        end else begin
          next_tries = '0;
        end
      end
      S_GRACE: begin
        next_cnt = cnt + 32'h1;
        if (!fault) next_st = S_RUN;
        else if (cnt >= 32'(DELAY_CYC)) next_st = S_LATCH;
      end
      S_OFF: if (clear_ok) next_st = S_RUN;
      S_WAIT: begin
        next_cnt = cnt + 32'h1;
        if (cnt >= 32'(DELAY_CYC)) begin
          next_cnt = 32'h0;
          if (clear_ok) begin
            next_st = S_RUN;
            next_tries = tries + CW'(1);
          end else if (policy == RESP_RETRY_COUNT && tries >= retry_limit) begin
            next_st = S_LATCH;
          end else if (policy == RESP_RETRY_COUNT) begin
            next_tries = tries + CW'(1);
          end
        end
      end
      S_LATCH: if (restart) begin
        next_st = S_RUN;
        next_tries = '0;
      end
      default: next_st = S_RUN;
    endcase
    if (st == S_RUN && policy == RESP_RETRY_COUNT && fault && tries >= retry_limit && tries != '0)
      next_st = S_LATCH;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= S_RUN;
      cnt <= 32'h0;
      tries <= '0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      tries <= next_tries;
    end
  end

  assign stop = (st != S_RUN) && (st != S_GRACE);
  assign latched = (st == S_LATCH);
endmodule
`default_nettype wire

// file: bench/supervisor_asserts.sv
// port assertions for the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module supervisor_asserts
  import supervisor_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          enable,
  input wire logic          restart_cmd,
  input wire logic          ext_clock_mode,
  input wire logic [VW-1:0] output_sense_pin,
  input wire logic [VW-1:0] target,
  input wire logic [TW-1:0] die_temp,
  input wire logic [TW-1:0] temp_limit,
  input wire logic          overcurrent,
  input wire resp_t         ov_policy,
  input wire resp_t         oc_policy,
  input wire resp_t         ot_policy,
  input wire track_t        track_mode,
  input wire logic          high_drive_en,
  input wire logic          low_drive_en,
  input wire logic          power_good,
  input wire logic          fault_latched
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic ov_cond;
  // widened so the product cannot wrap at the top of the code range
  assign ov_cond = ({20'h0, output_sense_pin} * 32'h64) > ({20'h0, target} * 32'h73);
  chk_pg_ov_drop: assert property (ov_cond [*3] |-> !power_good)
    else $error("power good held during overvoltage");
  chk_ov_extclk: assert property ((ov_cond && ext_clock_mode) [*3] |-> !high_drive_en && !low_drive_en)
    else $error("overvoltage on external clock did not shut down");
  chk_ov_high_off: assert property ((ov_cond && ov_policy == RESP_LOW_SIDE_ON) [*3] |-> !high_drive_en)
    else $error("high side left on during overvoltage");
  chk_oc_stop: assert property ((overcurrent && oc_policy == RESP_SHUTDOWN) [*3] |-> !high_drive_en && !low_drive_en)
    else $error("overcurrent did not shut down");
  chk_temp_stop: assert property ((die_temp > temp_limit && ot_policy == RESP_SHUTDOWN) [*3]
    |-> !high_drive_en && !low_drive_en)
    else $error("over temperature did not shut down");
  chk_pg_drives: assert property ($rose(power_good) |-> high_drive_en && low_drive_en)
    else $error("power good without both drives");
  // the latch output clears two cycles after the restart, so the previous cycle must be quiet too
  chk_latch_sticky: assert property (fault_latched && enable && $past(enable) && !restart_cmd && !$past(restart_cmd) |=> fault_latched)
    else $error("latched fault cleared without restart");
  chk_latch_dark: assert property (fault_latched |-> !high_drive_en)
    else $error("high side on while latched off");
  chk_start_wait: assert property ($rose(enable) && track_mode == TRK_OFF |=> !high_drive_en)
    else $error("drive before start delay");
  cov_pg: cover property ($rose(power_good));
  cov_latch: cover property ($rose(fault_latched));
  cov_lowside: cover property (low_drive_en && !high_drive_en && ov_cond);
endmodule
bind supply_fault_supervisor supervisor_asserts chk (.*);
`default_nettype wire

// file: bench/power_stage_model.sv
// behavioural power stage and output filter seen through the sense pin
`timescale 1ns/1ps
`default_nettype none
module power_stage_model
  import supervisor_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          high_drive_en,
  input  wire logic          low_drive_en,
  input  wire logic [VW-1:0] working_target,
  input  wire logic          hold_en,
  input  wire logic [VW-1:0] hold_v,
  output logic      [VW-1:0] vout
);
  // an outside source may pin the rail; with neither switch driven the rail keeps its bias
  always_ff @(posedge clk) begin
    if (hold_en) begin
      vout <= hold_v;
    end else if (high_drive_en && low_drive_en) begin
      vout <= working_target;
    end else if (low_drive_en) begin
      vout <= vout - (vout >> 3);
    end
  end
endmodule
`default_nettype wire

// file: bench/supply_fault_supervisor_tb.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module supply_fault_supervisor_tb;
  import supervisor_pkg::*;
  localparam int DLY = 8;
  int            seed = 28192;
  int            miscompares = 0;
  int            n_tests = 0;
  int            waited;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          enable = 1'b0, restart_cmd = 1'b0, ext_clock_mode = 1'b0, strap_mode = 1'b0;
  logic [VW-1:0] input_low_lockout_serial = 12'hc80, input_low_lockout_strap = 12'hc80, input_voltage = 12'hfff;
  logic [VW-1:0] target = 12'h400, follow_reference_pin = 12'h0, hold_v = 12'h0, output_sense_pin;
  logic          hold_en = 1'b1, overcurrent = 1'b0, track_no_decrease = 1'b0, share_member = 1'b0;
  logic [TW-1:0] die_temp = 8'h19, temp_limit = THERM_LIMIT_DEF;
  resp_t         uv_policy = RESP_SHUTDOWN, ov_policy = RESP_SHUTDOWN;
  resp_t         oc_policy = RESP_SHUTDOWN, ot_policy = RESP_SHUTDOWN;
  logic [CW-1:0] retry_limit = 4'h2;
  track_t        track_mode = TRK_OFF;
  logic [6:0]    track_ratio_pct = 7'h32;
  logic [31:0]   start_delay_cyc = 32'h10, ramp_cyc = 32'h20;
  logic          high_drive_en, low_drive_en, power_good, ov_fault, fault_latched;
  logic [VW-1:0] working_target;

  always #2 clk = ~clk;

  supply_fault_supervisor #(.DELAY_CYC(DLY)) dut (.*);
  power_stage_model stage (.clk(clk), .high_drive_en(high_drive_en), .low_drive_en(low_drive_en),
    .working_target(working_target), .hold_en(hold_en), .hold_v(hold_v), .vout(output_sense_pin));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  function automatic logic pick(int k);
    return k == 0 ? power_good : k == 1 ? high_drive_en : fault_latched;
  endfunction

  // bounded wait; running out of cycles ends the run
  task automatic wait_on(int k, int lim);
    waited = 0;
    n_tests++;
    while (pick(k) !== 1'b1 && waited < lim) begin
      @(negedge clk);
      waited++;
    end
    if (pick(k) !== 1'b1) begin
      miscompares++;
      $display("Error wait %0d expected 1 seen 0", k);
      complete_run();
    end
  endtask

  // one logic source drives the group enable; low also clears any latch
  task automatic start_up(logic [VW-1:0] bias);
    enable = 1'b0;
    hold_v = bias;
    hold_en = 1'b1;
    repeat (4) @(negedge clk);
    hold_en = 1'b0;
    enable = 1'b1;
  endtask

  task automatic set_fault(int k, logic v);
    case (k)
      0: overcurrent = v;
      1: die_temp = v ? temp_limit + 8'h01 : temp_limit - 8'h14;
      default: input_voltage = v ? 12'hb22 : 12'hfff;
    endcase
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("drives", {30'h0, high_drive_en, low_drive_en}, 32'h0);
    target = 12'h400 + 12'($random(seed) & 32'h1ff);
    start_up(target >> 1);
    wait_on(1, 64);
    check("start_delay", 32'(waited >= 16), 32'h1);
    check("working_target", 32'(working_target), 32'(target >> 1));
    wait_on(0, 48);
    for (int e = 0; e < 2; e++) begin
      for (int p = 0; p < 2; p++) begin
        ext_clock_mode = e[0];
        ov_policy = p == 1 ? RESP_LOW_SIDE_ON : RESP_SHUTDOWN;
        start_up(12'h0);
        wait_on(0, 96);
        hold_v = 12'((32'(target) * 115) / 100 + 32'h8);
        hold_en = 1'b1;
        repeat (4) @(negedge clk);
        check("ov_power_good", 32'(power_good), 32'h0);
        check("ov_high", 32'(high_drive_en), 32'h0);
        check("ov_low", 32'(low_drive_en), 32'(p == 1 && e == 0));
        hold_en = 1'b0;
      end
    end
    ext_clock_mode = 1'b0;
    ov_policy = RESP_SHUTDOWN;
    for (int k = 0; k < 3; k++) begin
      for (int p = 0; p < 2; p++) begin
        uv_policy = p == 1 ? RESP_CONTINUE : RESP_SHUTDOWN;
        oc_policy = uv_policy;
        ot_policy = uv_policy;
        start_up(12'h0);
        wait_on(0, 96);
        set_fault(k, 1'b1);
        repeat (4) @(negedge clk);
        check("fault_high", 32'(high_drive_en), 32'(p));
        set_fault(k, 1'b0);
        wait_on(1, 200);
      end
    end
    uv_policy = RESP_SHUTDOWN;
    ot_policy = RESP_SHUTDOWN;
    oc_policy = RESP_RETRY_COUNT;
    start_up(12'h0);
    wait_on(0, 96);
    overcurrent = 1'b1;
    wait_on(2, 2000);
    overcurrent = 1'b0;
    repeat (40) @(negedge clk);
    check("latched", 32'(fault_latched), 32'h1);
    check("latched_high", 32'(high_drive_en), 32'h0);
    restart_cmd = 1'b1;
    @(negedge clk);
    restart_cmd = 1'b0;
    wait_on(1, 200);
    oc_policy = RESP_SHUTDOWN;
    start_up(12'((32'(target) * 120) / 100));
    repeat (30) @(negedge clk);
    check("prebias_ov", 32'(ov_fault), 32'h1);
    check("prebias_high", 32'(high_drive_en), 32'h0);
    // the bench plays the group master: reference held at half the target, not tracking, ramp features off
    follow_reference_pin = target >> 1;
    for (int m = 1; m < 3; m++) begin
      track_mode = track_t'(m);
      start_up(12'h0);
      repeat (8) @(negedge clk);
      check("track_target", 32'(working_target), m == 1 ? 32'(target >> 1) : 32'(target >> 2));
    end
    complete_run();
  end
endmodule
`default_nettype wire
